// ---- rtl/qes_scaler.sv ----
// quadrature decoder, position counter and per-port scaled encoder outputs
`timescale 1ns/1ns
`default_nettype none

module qes_scaler import qes_pkg::*; #(
  parameter int PORTS = QES_PORTS,
  parameter int DIV_W = QES_DIV_W,
  parameter int POS_W = QES_POS_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // encoder pins
  input wire logic enc_a,
  input wire logic enc_b,
  // per-port divide factors, zero treated as one
  input wire logic [PORTS*DIV_W-1:0] div_factor,
  // per-port scaled output selects
  input wire logic [PORTS-1:0] sel_line_trig,
  input wire logic [PORTS-1:0] sel_timebase,
  input wire logic [PORTS-1:0] sel_trig_out,
  // position read request and answer
  input wire logic pos_req,
  output logic [POS_W-1:0] pos_value,
  output logic pos_valid,
  // decoded direction and step
  output logic dir_cw,
  output logic step_out,
  // scaled encoder results per port
  output logic [PORTS-1:0] scaled_edge,
  output logic [PORTS-1:0] line_trig,
  output logic [PORTS-1:0] pg_timebase,
  output logic [PORTS-1:0] trig_line_out
);

  // whole module state
  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] ab_prev;
    logic dir;
    logic step;
    logic [POS_W-1:0] pos;
    logic [POS_W-1:0] pos_rd;
    logic pos_vld;
    logic [PORTS-1:0][DIV_W:0] lag;
    logic [PORTS-1:0][DIV_W-1:0] cnt;
    logic [PORTS-1:0] edge_p;
    logic [PORTS-1:0] ltrig;
    logic [PORTS-1:0] tbase;
    logic [PORTS-1:0] tout;
  } qes_state_t;

  qes_state_t st_r;
  qes_state_t st_nxt;

  // gray position of a two-bit quadrature code
  // a leading b walks 00, 10, 11, 01 as positions 0 to 3
  function automatic logic [1:0] qes_phase(input logic [1:0] ab);
    qes_phase = {ab[0], ab[1] ^ ab[0]};
  endfunction

  // decode one transition: step valid and direction
  function automatic qes_step_t qes_decode(input logic [1:0] prv, input logic [1:0] cur);
    logic [1:0] d;
    d = qes_phase(cur) - qes_phase(prv);
    qes_decode.step = (d == 2'h1) || (d == 2'h3);
    qes_decode.cw = (d == 2'h1);
  endfunction

  // per-port divide factor, zero read as one
  // a zero factor would also fire on every forward step, so it acts as one
  function automatic logic [DIV_W-1:0] qes_div(input int p, input logic [PORTS*DIV_W-1:0] v);
    logic [DIV_W-1:0] f;
    f = v[p*DIV_W +: DIV_W];
    qes_div = (f == '0) ? DIV_W'(1) : f;
  endfunction

  qes_step_t dec;

  // next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = {enc_a, enc_b};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.ab_prev = st_r.sync2;
    dec = qes_decode(st_r.ab_prev, st_r.sync2);
    st_nxt.step = dec.step;
    if (dec.step) begin
      st_nxt.dir = dec.cw ? QES_DIR_CW : QES_DIR_CCW;
    end
    if (dec.step) begin
      st_nxt.pos = dec.cw ? st_r.pos + POS_W'(1) : st_r.pos - POS_W'(1);
    end
    st_nxt.pos_vld = pos_req;
    if (pos_req) begin
      st_nxt.pos_rd = st_r.pos;
    end
    for (int p = 0; p < PORTS; p++) begin
      st_nxt.edge_p[p] = 1'b0;
      // reverse steps owed before forward counts
      if (dec.step && !dec.cw) begin
        st_nxt.lag[p] = st_r.lag[p] + (DIV_W+1)'(1);
      end else if (dec.step && dec.cw) begin
        if (st_r.lag[p] != '0) begin
          st_nxt.lag[p] = st_r.lag[p] - (DIV_W+1)'(1);
        end else if (st_r.cnt[p] + DIV_W'(1) >= qes_div(p, div_factor)) begin
          st_nxt.cnt[p] = '0;
          st_nxt.edge_p[p] = 1'b1;
        end else begin
          st_nxt.cnt[p] = st_r.cnt[p] + DIV_W'(1);
        end
      end
      st_nxt.ltrig[p] = st_nxt.edge_p[p] & sel_line_trig[p];
      st_nxt.tbase[p] = st_nxt.edge_p[p] & sel_timebase[p];
      st_nxt.tout[p] = st_nxt.edge_p[p] & sel_trig_out[p];
    end
  end

  // state register
  // synchronous reset, direction starts clockwise
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_r <= '0;
      st_r.dir <= QES_DIR_CW;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flops
  assign pos_value = st_r.pos_rd;
  assign pos_valid = st_r.pos_vld;
  assign dir_cw = st_r.dir;
  assign step_out = st_r.step;
  assign scaled_edge = st_r.edge_p;
  assign line_trig = st_r.ltrig;
  assign pg_timebase = st_r.tbase;
  assign trig_line_out = st_r.tout;

  a_cw_count_up: assert property (@(posedge clk_sys) disable iff (reset)
    st_r.step && st_r.dir |-> st_r.pos == $past(st_r.pos) + POS_W'(1))
    else $error("clockwise step did not increment position");

  a_ccw_count_down: assert property (@(posedge clk_sys) disable iff (reset)
    st_r.step && !st_r.dir |-> st_r.pos == $past(st_r.pos) - POS_W'(1))
    else $error("counter-clockwise step did not decrement position");

  a_double_change: assert property (@(posedge clk_sys) disable iff (reset)
    (st_r.ab_prev ^ st_r.sync2) == 2'h3 |=> !st_r.step)
    else $error("both channels changed yet a step was counted");

  // no port 0 scaled edge without a forward step
  a_edge_forward: assert property (@(posedge clk_sys) disable iff (reset)
    st_r.edge_p[0] |-> st_r.step && st_r.dir)
    else $error("scaled edge without forward step");

  a_div_range: assert property (@(posedge clk_sys) disable iff (reset)
    st_r.cnt[0] < qes_div(0, div_factor) || $changed(div_factor))
    else $error("divider count reached the factor");

  // port 0 line trigger follows edge and select
  a_line_trig: assert property (@(posedge clk_sys) disable iff (reset)
    st_r.ltrig[0] == (st_r.edge_p[0] && $past(sel_line_trig[0])))
    else $error("line trigger does not match scaled edge");

  // position answer one cycle after request
  a_pos_read: assert property (@(posedge clk_sys) disable iff (reset)
    pos_req |=> pos_valid && pos_value == $past(st_r.pos))
    else $error("position read answer wrong");

  // scaled edge only on a step
  a_edge_step: assert property (@(posedge clk_sys) disable iff (reset)
    $past(|st_nxt.edge_p) |-> st_r.step)
    else $error("scaled edge without decoded step");

  // per-port checks, one set for each scaler
  for (genvar g = 0; g < PORTS; g++) begin : g_port
    // owed reverse steps block the edge
    a_owed_no_edge: assert property (@(posedge clk_sys) disable iff (reset)
      st_r.lag[g] != '0 && dec.step && dec.cw |=> !st_r.edge_p[g])
      else $error("scaled edge while reverse steps were owed");

    // each port edge needs forward step
    a_port_forward: assert property (@(posedge clk_sys) disable iff (reset)
      st_r.edge_p[g] |-> st_r.step && st_r.dir)
      else $error("port scaled edge without forward step");

    // each port counter below own factor
    a_port_div: assert property (@(posedge clk_sys) disable iff (reset)
      st_r.cnt[g] < qes_div(g, div_factor) || $changed(div_factor))
      else $error("port divider count reached its factor");

    // trigger line follows edge and select
    a_port_tout: assert property (@(posedge clk_sys) disable iff (reset)
      st_r.tout[g] == (st_r.edge_p[g] && $past(sel_trig_out[g])))
      else $error("trigger line output does not match scaled edge");
  end

endmodule
`default_nettype wire

// ---- rtl/qes_pkg.sv ----
// package for the quadrature encoder scaler: widths, resets, carriers
package qes_pkg;
  // default port count and widths
  localparam int QES_PORTS = 2;
  localparam int QES_DIV_W = 16;
  localparam int QES_POS_W = 32;
  // reset values
  localparam logic [1:0] QES_AB_RST = 2'h0;
  localparam logic QES_DIR_CW = 1'b1;
  localparam logic QES_DIR_CCW = 1'b0;

  // decoded step from the quadrature decoder
  typedef struct packed {
    logic step;
    logic cw;
  } qes_step_t;
endpackage

// ---- tb/qes_enc_model.sv ----
// rotary encoder model driving the two quadrature channels
`timescale 1ns/1ns
`default_nettype none
module qes_enc_model (
  // clock
  input wire logic clk_sys,
  // channel pins
  output logic enc_a,
  output logic enc_b
);
  logic [1:0] ph = 2'h0; // phase index of the code tracks
  assign enc_a = ph[1] ^ ph[0];
  assign enc_b = ph[1];
  // moves 1 forward, 3 reverse, 2 both channels at once
  task move(input logic [1:0] d);
    @(posedge clk_sys);
    #1 ph = ph + d;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
endmodule
`default_nettype wire

// ---- tb/qes_scaler_test.sv ----
// self-checking testbench for the quadrature encoder scaler
`timescale 1ns/1ns
`default_nettype none
module qes_scaler_test;
  logic clk_sys = 1'b0, reset = 1'b1, pos_req = 1'b0;
  logic [31:0] div = 32'h00000003; // port 0 by 3, port 1 zero acts as 1
  logic [1:0] sel_lt = 2'h1, sel_pt = 2'h2, sel_to = 2'h3; // per-port output selects
  logic [31:0] pos_value;
  logic pos_valid, dir_cw, step_out, enc_a, enc_b;
  logic [1:0] se, lt, pt, tr;
  wire logic [7:0] ev;
  int mismatches = 0, checked = 0;
  int cnt[9]; // pulse counts per output bit, zero at start
  assign ev = {tr, pt, lt, se};
  always #5 clk_sys = ~clk_sys;
  // counts every pulse of the scaled outputs and steps
  always @(posedge clk_sys) begin
    for (int i = 0; i < 8; i++) if (ev[i] === 1'b1) cnt[i]++;
    if (step_out === 1'b1) cnt[8]++;
  end
  qes_enc_model qes_enc_model_i (.clk_sys(clk_sys), .enc_a(enc_a), .enc_b(enc_b));
  qes_scaler qes_scaler_i (.clk_sys(clk_sys), .reset(reset), .enc_a(enc_a), .enc_b(enc_b),
    .div_factor(div), .sel_line_trig(sel_lt), .sel_timebase(sel_pt), .sel_trig_out(sel_to),
    .pos_req(pos_req), .pos_value(pos_value), .pos_valid(pos_valid), .dir_cw(dir_cw),
    .step_out(step_out), .scaled_edge(se), .line_trig(lt), .pg_timebase(pt),
    .trig_line_out(tr));
  task chk(input bit ok, input string m);
    checked++;
    if (!ok) begin
      mismatches++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  // expected counts as eight four-bit fields, output bit 0 lowest
  task ccmp(input logic [31:0] e);
    for (int i = 0; i < 8; i++) chk(cnt[i] == e[i*4 +: 4], "scaled pulse count");
  endtask
  task rdpos(input logic [31:0] e);
    @(posedge clk_sys);
    #1 pos_req = 1'b1;
    @(posedge clk_sys);
    #1 pos_req = 1'b0;
    chk(pos_valid === 1'b1 && pos_value === e, "position read");
  endtask
  task t_scale;
    repeat (6) qes_enc_model_i.move(2'h1);
    chk(dir_cw === 1'b1 && cnt[8] == 6, "forward steps");
    ccmp(32'h62600262);
    $display("done scale");
  endtask
  task t_reverse;
    repeat (2) qes_enc_model_i.move(2'h3);
    chk(dir_cw === 1'b0, "reverse direction");
    repeat (2) qes_enc_model_i.move(2'h1);
    ccmp(32'h62600262);
    $display("done reverse");
  endtask
  task t_position;
    qes_enc_model_i.move(2'h1);
    ccmp(32'h72700272);
    rdpos(32'h00000007);
    $display("done position");
  endtask
  task t_both;
    qes_enc_model_i.move(2'h2);
    chk(cnt[8] == 11 && dir_cw === 1'b1, "both change ignored");
    rdpos(32'h00000007);
    $display("done both");
  endtask
  task t_select;
    sel_lt = 2'h2;
    sel_pt = 2'h1;
    sel_to = 2'h0;
    repeat (3) qes_enc_model_i.move(2'h1);
    chk(cnt[8] == 14 && dir_cw === 1'b1, "steps after select change");
    ccmp(32'h727132A3);
    rdpos(32'h0000000A);
    $display("done select");
  endtask
  task results;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    #1 reset = 1'b0;
    repeat (4) @(posedge clk_sys);
    t_scale;
    t_reverse;
    t_position;
    t_both;
    t_select;
    results;
  end
  // watchdog well beyond the roughly 95 cycles of the tests
  initial begin
    repeat (2000) @(posedge clk_sys);
    mismatches++;
    results;
  end
endmodule
`default_nettype wire
